//--- fault_irq_pkg.sv
// Shared constants and types for the powerline fault and interrupt block.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package fault_irq_pkg;
    // Register byte offsets
    localparam logic [7:0] ctl1_off = 8'h00;
    localparam logic [7:0] ctl2_off = 8'h04;
    localparam logic [7:0] flag_off = 8'h08;
    localparam logic [7:0] irq_stat_off = 8'h0c;
    localparam logic [7:0] irq_mask_off = 8'h10;
    localparam logic [7:0] path_off = 8'h14;
    // Field positions
    localparam int unsigned cfg_zero_bit = 7;
    localparam int unsigned cur_bit = 6;
    localparam int unsigned therm_bit = 5;
    localparam int unsigned cal_lsb = 0;
    localparam int unsigned tx_en_bit = 0;
    localparam int unsigned rx_en_bit = 1;
    // Reset values
    localparam logic [7:0] ctl1_rst = 8'h00;
    localparam logic [7:0] ctl2_rst = 8'h00;
    localparam logic [1:0] mask_rst = 2'h0;
    // Calibration routings
    typedef enum logic [1:0] {
        cal_off_e = 2'h0,
        cal_tx_e = 2'h1,
        cal_rx_e = 2'h2,
        cal_txgain_e = 2'h3
    } cal_mode_t;
    // Routing switches for the analog chain
    typedef struct packed {
        logic tx_gain;
        logic tx_filter;
        logic rx_gain1;
        logic rx_filter;
        logic rx_gain2;
    } cal_route_t;
    // Analog event inputs
    typedef struct packed {
        logic cur_limit;
        logic temp_hi;
        logic temp_lo;
    } fault_in_t;
endpackage

//--- powerline_fault_interrupt_ctrl.sv
// Fault flags, interrupt, thermal hysteresis, shutdown and path-ready logic.
// Assumes analog status inputs are asynchronous; registers written over APB.
//
// What this block does
// - Shutdown low runs normally; shutdown high sets low power and stops amplifier, routing, ready pins and bus; flag logic keeps running.
// - Shutdown never disturbs registers; they keep their values across it.
// - Current limit with enable bit 6 set sets flag bit 6 and interrupts.
// - Current-overload flag stays set until the host clears it.
// - Enable clear: amplifier still limits, flag unchanged, no interrupt.
// - Amplifier off above upper temperature, back on at lower threshold.
// - Thermal overload with enable bit 5 set sets flag bit 5 and interrupts.
// - Thermal-overload flag stays set until the host clears it.
// - Enable clear: thermal shutoff still happens, flag unchanged, no interrupt.
// - Interrupt is signalled by driving the output low; host reads flags.
// - Control bit 7 must be zero; bits 6 and 5 enable, reset zero.
// - Open-drain transmit-ready high only while transmit path enabled and ready.
// - Open-drain receive-ready high only while receive path enabled and ready.
// - Three calibration routings offered over the analog chain.
// - Calibration routing selected by the first control register.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module powerline_fault_interrupt_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins and analog status
    input wire logic shutdown_in,
    input wire fault_irq_pkg::fault_in_t fault_in,
    input wire logic tx_path_ok,
    input wire logic rx_path_ok,
    // Outputs
    output logic int_n,
    output logic irq,
    output logic pa_enable,
    output logic low_power,
    output logic tx_ready_o,
    output logic tx_ready_oe_n,
    output logic rx_ready_o,
    output logic rx_ready_oe_n,
    output fault_irq_pkg::cal_route_t cal_route
);
    import fault_irq_pkg::*;

    // Synchronisers
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_ff <= 6'h00;
            sync2_ff <= 6'h00;
        end else begin
            sync1_ff <= {shutdown_in, fault_in, tx_path_ok, rx_path_ok};
            sync2_ff <= sync1_ff;
        end
    end
    wire logic sd_s = sync2_ff[5];
    wire logic cur_s = sync2_ff[4];
    wire logic thi_s = sync2_ff[3];
    wire logic tlo_s = sync2_ff[2];
    wire logic txok_s = sync2_ff[1];
    wire logic rxok_s = sync2_ff[0];

    // Registers
    logic [7:0] ctl1_ff;
    logic [7:0] ctl2_ff;
    logic [1:0] flag_ff;
    logic [1:0] stat_ff;
    logic [1:0] mask_ff;
    logic [1:0] path_en_ff;
    logic hot_ff;

    // Bus decode; serial access frozen while shut down
    // Access completes only at the edge where pready stands high
    wire logic acc = psel && penable && pready && !sd_s;
    wire logic wr = acc && pwrite;
    wire logic rd = acc && !pwrite;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction
    wire logic known = hit(paddr, ctl1_off) || hit(paddr, ctl2_off) ||
        hit(paddr, flag_off) || hit(paddr, irq_stat_off) ||
        hit(paddr, irq_mask_off) || hit(paddr, path_off);

    // Thermal hysteresis: trip above upper, release at lower
    wire logic nxt_hot = thi_s ? 1'b1 : (tlo_s ? hot_ff : 1'b0);
    wire logic cur_en = ctl2_ff[cur_bit];
    wire logic therm_en = ctl2_ff[therm_bit];
    wire logic cur_evt = cur_s && cur_en;
    wire logic therm_evt = thi_s && therm_en;
    // Host clears a flag by writing one; a new event wins
    wire logic [1:0] flag_clr = (wr && hit(paddr, flag_off)) ?
        {pwdata[cur_bit], pwdata[therm_bit]} : 2'h0;
    wire logic [1:0] flag_set = {cur_evt, therm_evt};
    wire logic [1:0] nxt_flag = flag_set | (flag_ff & ~flag_clr);
    wire logic [1:0] stat_clr = (rd && hit(paddr, irq_stat_off)) ? 2'h3 : 2'h0;
    wire logic [1:0] nxt_stat = flag_set | (stat_ff & ~stat_clr);
    wire logic flag_any = |nxt_flag;
    wire logic irq_any = |(nxt_stat & mask_ff);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl1_ff <= ctl1_rst;
            ctl2_ff <= ctl2_rst;
            mask_ff <= mask_rst;
            path_en_ff <= 2'h0;
        end else if (wr) begin
            // Registers only change on writes, so shutdown leaves them intact
            if (hit(paddr, ctl1_off)) begin
                ctl1_ff <= pwdata[7:0];
            end
            if (hit(paddr, ctl2_off)) begin
                ctl2_ff <= pwdata[7:0];
            end
            if (hit(paddr, irq_mask_off)) begin
                mask_ff <= pwdata[1:0];
            end
            if (hit(paddr, path_off)) begin
                path_en_ff <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hot_ff <= 1'b0;
            flag_ff <= 2'h0;
            stat_ff <= 2'h0;
        end else begin
            hot_ff <= nxt_hot;
            flag_ff <= nxt_flag;
            stat_ff <= nxt_stat;
        end
    end

    // Read mux
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0;
        if (hit(paddr, ctl1_off)) begin
            rdata[7:0] = ctl1_ff;
        end
        if (hit(paddr, ctl2_off)) begin
            rdata[7:0] = ctl2_ff;
        end
        if (hit(paddr, flag_off)) begin
            rdata[cur_bit] = flag_ff[1];
            rdata[therm_bit] = flag_ff[0];
        end
        if (hit(paddr, irq_stat_off)) begin
            rdata[1:0] = stat_ff;
        end
        if (hit(paddr, irq_mask_off)) begin
            rdata[1:0] = mask_ff;
        end
        if (hit(paddr, path_off)) begin
            rdata[1:0] = path_en_ff;
        end
    end

    // Calibration routing decode
    cal_mode_t mode;
    assign mode = cal_mode_t'(ctl1_ff[cal_lsb +: 2]);
    cal_route_t nxt_route;
    always_comb begin
        nxt_route = '0;
        case (mode)
            cal_tx_e: nxt_route = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
            cal_rx_e: nxt_route = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
            cal_txgain_e: nxt_route = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
            default: nxt_route = '0;
        endcase
        if (sd_s) nxt_route = '0;
    end

    wire logic tx_rdy = path_en_ff[tx_en_bit] && txok_s && !sd_s;
    wire logic rx_rdy = path_en_ff[rx_en_bit] && rxok_s && !sd_s;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            int_n <= 1'b1;
            irq <= 1'b0;
            pa_enable <= 1'b0;
            low_power <= 1'b0;
            tx_ready_oe_n <= 1'b0;
            rx_ready_oe_n <= 1'b0;
            cal_route <= '0;
            tx_ready_o <= 1'b0;
            rx_ready_o <= 1'b0;
        end else begin
            // One-cycle answer; none while shut down
            pready <= psel && !pready && !sd_s;
            pslverr <= psel && !pready && !sd_s && !known;
            prdata <= rdata;
            int_n <= !flag_any;
            irq <= irq_any;
            pa_enable <= !nxt_hot && !sd_s;
            low_power <= sd_s;
            tx_ready_oe_n <= tx_rdy;
            rx_ready_oe_n <= rx_rdy;
            cal_route <= nxt_route;
            // Open-drain data stays low; the enable does the signalling
            tx_ready_o <= 1'b0;
            rx_ready_o <= 1'b0;
        end
    end

    // Checks
    // Named steps of the thermal cycle and of the flag clears
    sequence s_hot_warm;
        hot_ff && !thi_s && tlo_s;
    endsequence
    sequence s_cool_run;
        !thi_s && !tlo_s && !sd_s;
    endsequence
    sequence s_flags_drop;
        (flag_ff != 2'h0) ##1 (flag_ff == 2'h0);
    endsequence
    sequence s_cur_clear;
        flag_ff[1] && flag_clr[1] && !cur_evt;
    endsequence
    sequence s_therm_clear;
        flag_ff[0] && flag_clr[0] && !therm_evt;
    endsequence

    // Current overload flag
    AST_CUR_SET: assert property (@(posedge mclk) disable iff (sys_rst)
        cur_evt |=> flag_ff[1])
        else $error("Current flag not set");
    AST_CUR_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
        flag_ff[1] && !flag_clr[1] |=> flag_ff[1])
        else $error("Current flag lost");
    AST_CUR_CLR: assert property (@(posedge mclk) disable iff (sys_rst)
        s_cur_clear |=> !flag_ff[1])
        else $error("Current flag not cleared");
    AST_CUR_MASK: assert property (@(posedge mclk) disable iff (sys_rst)
        !cur_en && flag_clr == 2'h0 |=> $stable(flag_ff[1]))
        else $error("Flag moved");
    AST_CUR_INT: assert property (@(posedge mclk) disable iff (sys_rst)
        cur_evt |=> !int_n)
        else $error("No interrupt on current overload");
    AST_CUR_IRQ: assert property (@(posedge mclk) disable iff (sys_rst)
        cur_evt && mask_ff[1] |=> irq)
        else $error("No masked irq on current overload");

    // Thermal overload flag
    AST_THERM_SET: assert property (@(posedge mclk) disable iff (sys_rst)
        therm_evt |=> flag_ff[0])
        else $error("Thermal flag not set");
    AST_THERM_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
        flag_ff[0] && !flag_clr[0] |=> flag_ff[0])
        else $error("Thermal flag lost");
    AST_THERM_CLR: assert property (@(posedge mclk) disable iff (sys_rst)
        s_therm_clear |=> !flag_ff[0])
        else $error("Thermal flag not cleared");
    AST_THERM_MASK: assert property (@(posedge mclk) disable iff (sys_rst)
        !therm_en && flag_clr == 2'h0 |=> $stable(flag_ff[0]))
        else $error("Flag moved");
    AST_THERM_INT: assert property (@(posedge mclk) disable iff (sys_rst)
        therm_evt |=> !int_n)
        else $error("No interrupt on thermal overload");
    AST_THERM_IRQ: assert property (@(posedge mclk) disable iff (sys_rst)
        therm_evt && mask_ff[0] |=> irq)
        else $error("No masked irq on thermal overload");

    // Interrupt level
    AST_NO_INT_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
        !cur_en && !therm_en && flag_ff == 2'h0 |=> int_n)
        else $error("Interrupt while both enables clear");
    AST_INT_LOW: assert property (@(posedge mclk) disable iff (sys_rst)
        ##1 int_n == (flag_ff == 2'h0))
        else $error("Interrupt level wrong");
    AST_INT_RISE: assert property (@(posedge mclk) disable iff (sys_rst)
        s_flags_drop |-> int_n)
        else $error("Interrupt not released");

    // Amplifier thermal guard
    AST_PA_HOT: assert property (@(posedge mclk) disable iff (sys_rst)
        thi_s |=> !pa_enable && hot_ff)
        else $error("Amplifier not off");
    AST_PA_HYST: assert property (@(posedge mclk) disable iff (sys_rst)
        s_hot_warm |=> hot_ff && !pa_enable)
        else $error("Amplifier back on too early");
    AST_PA_COOL: assert property (@(posedge mclk) disable iff (sys_rst)
        s_cool_run |=> pa_enable && !hot_ff)
        else $error("Amplifier not back on");
    AST_PA_CYCLE: assert property (@(posedge mclk) disable iff (sys_rst)
        s_hot_warm ##1 s_cool_run |=> pa_enable)
        else $error("Amplifier not released after cooling");
    AST_PA_GUARD_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
        thi_s && !therm_en |=> !pa_enable)
        else $error("Amplifier on while hot");

    // Shutdown
    AST_SD_FREEZE: assert property (@(posedge mclk) disable iff (sys_rst)
        sd_s |=> $stable(ctl2_ff) && $stable(ctl1_ff) &&
        $stable(mask_ff) && $stable(path_en_ff))
        else $error("Reg changed");
    AST_SD_POWER: assert property (@(posedge mclk) disable iff (sys_rst)
        sd_s |=> low_power && !pa_enable)
        else $error("Not in low power");
    AST_SD_BUS: assert property (@(posedge mclk) disable iff (sys_rst)
        sd_s |=> !pready)
        else $error("Bus answered in shutdown");
    AST_SD_ROUTE: assert property (@(posedge mclk) disable iff (sys_rst)
        sd_s |=> cal_route == '0)
        else $error("Routing active in shutdown");
    AST_SD_PINS: assert property (@(posedge mclk) disable iff (sys_rst)
        sd_s |=> !tx_ready_oe_n && !rx_ready_oe_n)
        else $error("Ready pin released in shutdown");

    // Ready pins
    AST_TX_RDY: assert property (@(posedge mclk) disable iff (sys_rst)
        !path_en_ff[tx_en_bit] |=> !tx_ready_oe_n)
        else $error("Tx ready high");
    AST_RX_RDY: assert property (@(posedge mclk) disable iff (sys_rst)
        !path_en_ff[rx_en_bit] |=> !rx_ready_oe_n)
        else $error("Rx ready high");
    AST_TX_UP: assert property (@(posedge mclk) disable iff (sys_rst)
        path_en_ff[tx_en_bit] && txok_s && !sd_s |=> tx_ready_oe_n)
        else $error("Tx ready not released");
    AST_RX_UP: assert property (@(posedge mclk) disable iff (sys_rst)
        path_en_ff[rx_en_bit] && rxok_s && !sd_s |=> rx_ready_oe_n)
        else $error("Rx ready not released");

    // Calibration routing
    AST_CAL_TX: assert property (@(posedge mclk) disable iff (sys_rst)
        !sd_s && mode == cal_tx_e |=> cal_route.tx_gain && cal_route.tx_filter &&
        !cal_route.rx_gain1 && !cal_route.rx_filter && !cal_route.rx_gain2)
        else $error("Transmit calibration routing wrong");
    AST_CAL_RX: assert property (@(posedge mclk) disable iff (sys_rst)
        !sd_s && mode == cal_rx_e |=> cal_route.tx_gain && !cal_route.tx_filter &&
        cal_route.rx_gain1 && cal_route.rx_filter && cal_route.rx_gain2)
        else $error("Receive calibration routing wrong");
    AST_CAL_TXG: assert property (@(posedge mclk) disable iff (sys_rst)
        !sd_s && mode == cal_txgain_e |=> cal_route.tx_gain && !cal_route.tx_filter &&
        !cal_route.rx_gain1 && !cal_route.rx_filter && !cal_route.rx_gain2)
        else $error("Gain calibration routing wrong");
    AST_CAL_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
        !sd_s && mode == cal_off_e |=> cal_route == '0)
        else $error("Routing active with calibration off");
endmodule

//--- fault_pins_model.sv
// Host-side pin model: pull-ups on the two open-drain ready pins.
// Assumes the device pulls a pin low while its enable is low.
`timescale 1ns/1ps
module fault_pins_model (
    // Device drive
    input wire logic tx_o,
    input wire logic tx_oe_n,
    input wire logic rx_o,
    input wire logic rx_oe_n,
    // Levels seen by the host
    output logic tx_pin,
    output logic rx_pin
);
    assign tx_pin = tx_oe_n ? 1'b1 : tx_o;
    assign rx_pin = rx_oe_n ? 1'b1 : rx_o;
endmodule

//--- test_powerline_fault_interrupt_ctrl.sv
// Self-checking bench for the fault and interrupt block.
// Assumes the package offsets and a zero-wait APB slave.
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; \
    $display("ERROR %s exp %h got %h", n, e, a); end end
module test_powerline_fault_interrupt_ctrl;
    import fault_irq_pkg::*;
    logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, err, shutdown_in;
    logic tx_path_ok, rx_path_ok, int_n, irq, pa_enable, low_power;
    logic tx_o, tx_oe_n, rx_o, rx_oe_n, tx_pin, rx_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] seed = 32'h0000dd26;
    fault_in_t fault_in;
    cal_route_t cal_route;
    int errors = 0;
    int num_checks = 0;
    powerline_fault_interrupt_ctrl powerline_fault_interrupt_ctrl_inst (.mclk(mclk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shutdown_in(shutdown_in), .fault_in(fault_in), .tx_path_ok(tx_path_ok),
        .rx_path_ok(rx_path_ok), .int_n(int_n), .irq(irq), .pa_enable(pa_enable),
        .low_power(low_power), .tx_ready_o(tx_o), .tx_ready_oe_n(tx_oe_n),
        .rx_ready_o(rx_o), .rx_ready_oe_n(rx_oe_n), .cal_route(cal_route));
    fault_pins_model fault_pins_model_inst (.tx_o(tx_o), .tx_oe_n(tx_oe_n), .rx_o(rx_o),
        .rx_oe_n(rx_oe_n), .tx_pin(tx_pin), .rx_pin(rx_pin));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic cal_route_t route_of(input logic [1:0] m);
        case (m)
            2'h1: return 5'h18;
            2'h2: return 5'h17;
            2'h3: return 5'h10;
            default: return 5'h00;
        endcase
    endfunction
    task automatic summarize();
        if (errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            errors++;
            summarize();
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {sys_rst, psel, penable, pwrite, shutdown_in, tx_path_ok, rx_path_ok} = 7'h40;
        paddr = 8'h00;
        pwdata = 32'h0;
        fault_in = '0;
        tick(8);
        sys_rst <= 1'b0;
        `CHK("int_n rst", 1'b1, int_n)
        apb(1'b0, ctl2_off, 32'h0);
        `CHK("ctl2 rst", 32'h0, rd)
        `CHK("pa rst", 1'b1, pa_enable)
        `CHK("lp rst", 1'b0, low_power)
        apb(1'b0, 8'h3c, 32'h0);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, ctl2_off, 32'h40);
        apb(1'b1, irq_mask_off, 32'h3);
        fault_in.cur_limit <= 1'b1;
        tick(6);
        `CHK("int_n cur", 1'b0, int_n)
        `CHK("irq cur", 1'b1, irq)
        fault_in.cur_limit <= 1'b0;
        tick(6);
        apb(1'b0, flag_off, 32'h0);
        `CHK("flag cur", 32'h40, rd)
        apb(1'b0, irq_stat_off, 32'h0);
        `CHK("stat", 32'h2, rd)
        apb(1'b0, irq_stat_off, 32'h0);
        `CHK("stat clr", 32'h0, rd)
        apb(1'b1, flag_off, 32'h40);
        tick(2);
        `CHK("int_n clr", 1'b1, int_n)
        `CHK("irq clr", 1'b0, irq)
        apb(1'b1, ctl2_off, 32'h0);
        fault_in.cur_limit <= 1'b1;
        tick(6);
        `CHK("int_n off", 1'b1, int_n)
        apb(1'b0, flag_off, 32'h0);
        `CHK("flag off", 32'h0, rd)
        fault_in <= 3'h3;
        tick(6);
        `CHK("pa guard", 1'b0, pa_enable)
        `CHK("int_n guard", 1'b1, int_n)
        `CHK("irq guard", 1'b0, irq)
        apb(1'b0, flag_off, 32'h0);
        `CHK("flag guard", 32'h0, rd)
        apb(1'b1, ctl2_off, 32'h20);
        tick(6);
        `CHK("pa hot", 1'b0, pa_enable)
        `CHK("int_n hot", 1'b0, int_n)
        fault_in <= 3'h1;
        tick(6);
        `CHK("pa hyst", 1'b0, pa_enable)
        fault_in <= 3'h0;
        tick(6);
        `CHK("pa cool", 1'b1, pa_enable)
        apb(1'b0, flag_off, 32'h0);
        `CHK("flag hot", 32'h20, rd)
        apb(1'b1, flag_off, 32'h20);
        tick(2);
        `CHK("int_n tclr", 1'b1, int_n)
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            apb(1'b1, ctl1_off, {30'h0, i[1:0]});
            apb(1'b1, path_off, {30'h0, seed[3:2]});
            tx_path_ok <= seed[4];
            rx_path_ok <= seed[5];
            tick(5);
            `CHK("route", route_of(i[1:0]), cal_route)
            `CHK("tx pin", seed[2] & seed[4], tx_pin)
            `CHK("rx pin", seed[3] & seed[5], rx_pin)
        end
        apb(1'b1, ctl1_off, 32'h2);
        shutdown_in <= 1'b1;
        tick(4);
        `CHK("low pwr", 1'b1, low_power)
        `CHK("sd route", 5'h00, cal_route)
        `CHK("sd pa", 1'b0, pa_enable)
        `CHK("sd tx pin", 1'b0, tx_pin)
        shutdown_in <= 1'b0;
        tick(4);
        `CHK("route kept", route_of(2'h2), cal_route)
        `CHK("pa back", 1'b1, pa_enable)
        apb(1'b0, ctl1_off, 32'h0);
        `CHK("ctl1 kept", 32'h2, rd)
        apb(1'b0, ctl2_off, 32'h0);
        `CHK("ctl2 kept", 32'h20, rd)
        summarize();
    end
endmodule
